// file: design/dtp_port.sv
// Dataport time-slot port card logic: four 64 kbps ports mapped onto WAN slots.
// Assumes host config and the WAN slot bus run on clk_i; DTE pins are asynchronous.
module dtp_port
  import dtp_pkg::*;
#(
  parameter logic [TO_W-1:0] LOOP_TIMEOUT_CYC = LOOP_TIMEOUT_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_we_i,
  input wire logic [1:0] cfg_port_i,
  input wire dtp_port_cfg_t cfg_i,
  input wire logic cfg_ext_clk_i,
  input wire logic [NLINK-1:0] link_e1_i,
  input wire logic [NLINK-1:0] link_sig_i,
  input wire logic wan_stb_i,
  input wire dtp_slot_t wan_rx_i,
  input wire logic [NPORT-1:0] dte_txd_i,
  input wire logic dte_ext_bit_clk_i,
  input wire logic dte_ext_byte_clk_i,
  output dtp_port_cfg_t [NPORT-1:0] port_cfg_o,
  output logic ext_clk_o,
  output logic [NPORT-1:0] clk_na_o,
  output logic [NPORT-1:0] slot_claim_o,
  output logic [NPORT-1:0] loop_latched_o,
  output logic wan_tx_valid_o,
  output dtp_slot_t wan_tx_o,
  output logic [NPORT-1:0] dte_rxd_o,
  output logic [NPORT-1:0] dte_bit_clk_o,
  output logic [NPORT-1:0] dte_byte_clk_o
);

  typedef struct packed {
    dtp_port_cfg_t [NPORT-1:0] cfg;
    logic ext_clk;
    logic [NPORT-1:0] clk_na;
    logic [NPORT-1:0] txd_m;
    logic [NPORT-1:0] txd_s;
    logic [1:0] ext_m;
    logic [1:0] ext_s;
    logic [1:0] ext_d;
    logic [ACC_W-1:0] acc;
    logic bit_clk;
    logic [2:0] bit_cnt;
    logic byte_clk;
    logic [NPORT-1:0][7:0] tx_sr;
    logic [NPORT-1:0][7:0] tx_byte;
    logic [NPORT-1:0][7:0] rx_byte;
    logic [NPORT-1:0][7:0] rx_sr;
    logic [NPORT-1:0] rxd;
    logic [NPORT-1:0] bclk_out;
    logic [NPORT-1:0] yclk_out;
    logic [NPORT-1:0][1:0] up_cnt;
    logic [NPORT-1:0][1:0] dn_cnt;
    logic [NPORT-1:0] latched;
    logic [NPORT-1:0][TO_W-1:0] to_cnt;
    logic [NPORT-1:0] claim;
    logic wan_tx_valid;
    dtp_slot_t wan_tx;
  } dtp_state_t;

  dtp_state_t s;
  dtp_state_t next_s;

  // Legal slot for the link type; used only for the slot claims, not for writes
  function automatic logic slot_ok(input logic [4:0] slot, input logic e1, input logic sig);
    logic ok;
    ok = 1'b0;
    if (!e1) begin
      ok = (slot >= SLOT_MIN) && (slot <= SLOT_MAX_T1);
    end else begin
      ok = (slot >= SLOT_MIN) && (slot <= SLOT_MAX_E1) && !(sig && slot == SLOT_E1_SIG);
    end
    return ok;
  endfunction

  // Byte sent for each loop code choice
  function automatic logic [7:0] gen_code(input dtp_gen_t g);
    logic [7:0] c;
    c = 8'h00;
    case (g)
      DTP_GEN_OCU: c = CODE_OCU;
      DTP_GEN_DSU: c = CODE_DSU;
      DTP_GEN_CSU: c = CODE_CSU;
      DTP_GEN_DS0: c = CODE_DS0;
      default: c = 8'h00;
    endcase
    return c;
  endfunction

  // Next-state logic for configuration, clocking, data path and loop detection
  always_comb begin
    logic [ACC_W-1:0] acc_sum;
    logic bit_tick;
    logic byte_end;
    logic found;
    logic int_tim;
    dtp_port_cfg_t w;
    next_s = s;
    acc_sum = '0;
    bit_tick = 1'b0;
    byte_end = 1'b0;
    found = 1'b0;
    int_tim = 1'b0;
    w = cfg_i;

    // Host write with card-wide mode and clock propagation
    if (cfg_we_i) begin
      if (!w.dest_wan) begin
        w.slot_number = SLOT_NA;
      end
      for (int p = 0; p < NPORT; p++) begin
        if (p == int'(cfg_port_i)) begin
          next_s.cfg[p] = w;
        end else if (w.mode == DTP_MODE_DP) begin
          next_s.cfg[p].mode = DTP_MODE_DP;
        end else if (s.cfg[p].mode == DTP_MODE_DP) begin
          next_s.cfg[p].mode = DTP_MODE_CONTR;
        end
      end
      next_s.ext_clk = cfg_ext_clk_i;
    end
    for (int p = 0; p < NPORT; p++) begin
      next_s.clk_na[p] = (next_s.cfg[p].mode != DTP_MODE_DP);
    end

    // Pin synchronisers
    // Only the second stage, and the third for the edge detect, feed logic; the first may still be settling
    next_s.txd_m = dte_txd_i;
    next_s.txd_s = s.txd_m;
    next_s.ext_m = {dte_ext_byte_clk_i, dte_ext_bit_clk_i};
    next_s.ext_s = s.ext_m;
    next_s.ext_d = s.ext_s;

    // Bit timing: fractional divider internally, DTE clocks externally
    // The accumulator keeps the long-run rate exact; each edge may jitter one system clock
    // G.703 ports ignore the clock source; mode spread lets port 0 speak for the card
    int_tim = !s.ext_clk || s.clk_na[0];
    if (int_tim) begin
      acc_sum = s.acc + HALF_STEP;
      if (acc_sum >= CLK_HZ) begin
        next_s.acc = acc_sum - CLK_HZ;
        next_s.bit_clk = !s.bit_clk;
        bit_tick = !s.bit_clk;
      end else begin
        next_s.acc = acc_sum;
      end
      byte_end = bit_tick && (s.bit_cnt == BITS_PER_BYTE_M1);
    end else begin
      next_s.acc = '0;
      bit_tick = s.ext_s[0] && !s.ext_d[0];
      byte_end = bit_tick && (s.ext_s[1] || s.bit_cnt == BITS_PER_BYTE_M1);
    end
    if (bit_tick) begin
      next_s.bit_cnt = byte_end ? 3'h0 : s.bit_cnt + 3'h1;
      next_s.byte_clk = byte_end;
    end

    // Clock outputs toward the DTE per port mode
    for (int p = 0; p < NPORT; p++) begin
      case (s.cfg[p].mode)
        DTP_MODE_DP: begin
          next_s.bclk_out[p] = !s.ext_clk && s.bit_clk;
          next_s.yclk_out[p] = !s.ext_clk && s.byte_clk;
        end
        DTP_MODE_CONTR: begin
          next_s.bclk_out[p] = s.bit_clk;
          next_s.yclk_out[p] = s.byte_clk;
        end
        default: begin
          next_s.bclk_out[p] = 1'b0;
          next_s.yclk_out[p] = 1'b0;
        end
      endcase
    end

    // Serial shifting toward and from the DTE, shared timing for both directions
    for (int p = 0; p < NPORT; p++) begin
      if (bit_tick) begin
        next_s.tx_sr[p] = {s.tx_sr[p][6:0], s.txd_s[p]};
        next_s.rxd[p] = s.rx_sr[p][7];
        next_s.rx_sr[p] = {s.rx_sr[p][6:0], 1'b0};
        if (byte_end) begin
          next_s.tx_byte[p] = {s.tx_sr[p][6:0], s.txd_s[p]};
          next_s.rx_sr[p] = (s.cfg[p].local_loop_select == DTP_LB_DTE) ?
                            s.tx_byte[p] : s.rx_byte[p];
        end
      end
    end

    // Slot claims from the port settings and link types
    // An illegal slot stays stored but is never claimed
    for (int p = 0; p < NPORT; p++) begin
      next_s.claim[p] = s.cfg[p].active && s.cfg[p].dest_wan &&
        slot_ok(s.cfg[p].slot_number, link_e1_i[s.cfg[p].link],
                link_sig_i[s.cfg[p].link]);
    end

    // WAN slot bus: answer the matching port one cycle after the strobe
    // If two ports claim one slot, the lowest port answers
    next_s.wan_tx_valid = 1'b0;
    next_s.wan_tx = wan_rx_i;
    for (int p = 0; p < NPORT; p++) begin
      if (wan_stb_i && s.claim[p] && !found && wan_rx_i.link == s.cfg[p].link &&
          wan_rx_i.slot == s.cfg[p].slot_number) begin
        found = 1'b0 | 1'b1;
        next_s.wan_tx_valid = 1'b1;
        if (s.cfg[p].local_loop_select == DTP_LB_NET || s.latched[p]) begin
          next_s.wan_tx.data = wan_rx_i.data;
        end else if (s.cfg[p].mode == DTP_MODE_DP &&
                     s.cfg[p].remote_loop_code_send != DTP_GEN_OFF) begin
          next_s.wan_tx.data = gen_code(s.cfg[p].remote_loop_code_send);
        end else begin
          next_s.wan_tx.data = s.tx_byte[p];
        end
        next_s.rx_byte[p] = wan_rx_i.data;
        // Latching loop code watch on the received slot byte
        if (s.cfg[p].latching_loop_detector != DTP_DET_OFF && s.cfg[p].mode == DTP_MODE_DP) begin
          if (wan_rx_i.data == gen_code(DTP_GEN_DS0) || wan_rx_i.data == CODE_OCU ||
              wan_rx_i.data == CODE_DSU || wan_rx_i.data == CODE_CSU) begin
            next_s.up_cnt[p] = (s.up_cnt[p] == CODE_MATCH_M1) ? s.up_cnt[p] : s.up_cnt[p] + 2'h1;
            if (s.up_cnt[p] == CODE_MATCH_M1 && !s.latched[p]) begin
              next_s.latched[p] = 1'b1;
              next_s.to_cnt[p] = '0;
            end
          end else begin
            next_s.up_cnt[p] = 2'h0;
          end
          if (wan_rx_i.data == CODE_LOOP_DOWN) begin
            next_s.dn_cnt[p] = (s.dn_cnt[p] == CODE_MATCH_M1) ? s.dn_cnt[p] : s.dn_cnt[p] + 2'h1;
            if (s.dn_cnt[p] == CODE_MATCH_M1) begin
              next_s.latched[p] = 1'b0;
            end
          end else begin
            next_s.dn_cnt[p] = 2'h0;
          end
        end
      end
    end

    // Timeout and mode or option gating of the latched loop
    // The counter restarts whenever the loop latches
    for (int p = 0; p < NPORT; p++) begin
      if (s.latched[p] && s.cfg[p].latching_loop_detector == DTP_DET_TO) begin
        next_s.to_cnt[p] = s.to_cnt[p] + TO_W'(1);
        if (s.to_cnt[p] >= LOOP_TIMEOUT_CYC - TO_W'(1)) begin
          next_s.latched[p] = 1'b0;
          next_s.to_cnt[p] = '0;
        end
      end
      if (s.cfg[p].latching_loop_detector == DTP_DET_OFF || s.cfg[p].mode != DTP_MODE_DP) begin
        next_s.latched[p] = 1'b0;
        next_s.up_cnt[p] = 2'h0;
        next_s.dn_cnt[p] = 2'h0;
        next_s.to_cnt[p] = '0;
      end
    end
  end

  // State register with synchronous reset to the default settings
  // Answer and loop state start clear so no stale answer follows reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.cfg <= {NPORT{CFG_RESET}};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign port_cfg_o = s.cfg;
  assign ext_clk_o = s.ext_clk;
  assign clk_na_o = s.clk_na;
  assign slot_claim_o = s.claim;
  assign loop_latched_o = s.latched;
  assign wan_tx_valid_o = s.wan_tx_valid;
  assign wan_tx_o = s.wan_tx;
  assign dte_rxd_o = s.rxd;
  assign dte_bit_clk_o = s.bclk_out;
  assign dte_byte_clk_o = s.yclk_out;

endmodule

// file: shared/dtp_pkg.sv
// Package for the dataport time-slot port block: sizes, codes, timing, carriers.
// Assumes a 25 MHz system clock shared by the host and the WAN slot bus.
package dtp_pkg;
  localparam int NPORT = 4;
  localparam int NLINK = 8;
  localparam int ACC_W = 26;
  localparam int TO_W = 34;

  // Clock rates and time constants
  localparam logic [ACC_W-1:0] CLK_HZ = 26'h017D_7840; // 25 MHz
  localparam logic [ACC_W-1:0] BIT_HZ = 26'h0000_FA00; // 64 kbps bit clock
  localparam logic [ACC_W-1:0] HALF_STEP = ACC_W'({BIT_HZ, 1'b0}); // Two half periods per bit
  localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7; // 8 kHz byte clock
  localparam logic [7:0] LOOP_TIMEOUT_MIN = 8'h0A; // Latched loop timeout in minutes
  localparam logic [7:0] SEC_PER_MIN = 8'h3C;
  localparam longint unsigned LOOP_TIMEOUT_CYC_L =
    longint'(LOOP_TIMEOUT_MIN) * longint'(SEC_PER_MIN) * longint'(CLK_HZ);
  localparam logic [TO_W-1:0] LOOP_TIMEOUT_CYC_DEF = TO_W'(LOOP_TIMEOUT_CYC_L);

  // Slot limits
  localparam logic [4:0] SLOT_MIN = 5'h01;
  localparam logic [4:0] SLOT_MAX_T1 = 5'h18;
  localparam logic [4:0] SLOT_MAX_E1 = 5'h1F;
  localparam logic [4:0] SLOT_E1_SIG = 5'h10;
  localparam logic [4:0] SLOT_NA = 5'h00;

  // Loop codes sent and watched for on the slot (plain defaults)
  localparam logic [7:0] CODE_OCU = 8'h2A;
  localparam logic [7:0] CODE_DSU = 8'h2C;
  localparam logic [7:0] CODE_CSU = 8'h28;
  localparam logic [7:0] CODE_DS0 = 8'h3A;
  localparam logic [7:0] CODE_LOOP_DOWN = 8'h24;
  localparam logic [1:0] CODE_MATCH_M1 = 2'h2; // Three matching code bytes in a row

  typedef enum logic [1:0] {
    DTP_MODE_DP = 2'b00, DTP_MODE_CONTR = 2'b01, DTP_MODE_CODIR = 2'b10
  } dtp_mode_t;
  typedef enum logic [1:0] {
    DTP_LB_OFF = 2'b00, DTP_LB_DTE = 2'b01, DTP_LB_NET = 2'b10
  } dtp_lb_t;
  typedef enum logic [2:0] {
    DTP_GEN_OFF = 3'b000, DTP_GEN_OCU = 3'b001, DTP_GEN_DSU = 3'b010,
    DTP_GEN_CSU = 3'b011, DTP_GEN_DS0 = 3'b100
  } dtp_gen_t;
  typedef enum logic [1:0] {
    DTP_DET_OFF = 2'b00, DTP_DET_ENAB = 2'b01, DTP_DET_TO = 2'b10
  } dtp_det_t;

  // Per-port settings as written by the host
  typedef struct packed {
    logic active;
    logic dest_wan;
    logic [2:0] link;
    logic [4:0] slot_number;
    dtp_mode_t mode;
    dtp_lb_t local_loop_select;
    dtp_gen_t remote_loop_code_send;
    dtp_det_t latching_loop_detector;
  } dtp_port_cfg_t;

  // One time-slot byte on the WAN slot bus
  typedef struct packed {
    logic [2:0] link;
    logic [4:0] slot;
    logic [7:0] data;
  } dtp_slot_t;

  localparam dtp_port_cfg_t CFG_RESET = '{
    active: 1'b0, dest_wan: 1'b0, link: 3'h0, slot_number: 5'h00,
    mode: DTP_MODE_DP, local_loop_select: DTP_LB_OFF,
    remote_loop_code_send: DTP_GEN_OFF, latching_loop_detector: DTP_DET_OFF
  };
endpackage

// file: verification/dtp_port_properties.sv
// Checker for the port card: slot claims, mode spread, clock select, loops, answers.
// Sees only the top ports; bound to every dtp_port below.
module dtp_port_props
  import dtp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_we_i,
  input wire dtp_port_cfg_t cfg_i,
  input wire logic cfg_ext_clk_i,
  input wire logic [NLINK-1:0] link_e1_i,
  input wire logic [NLINK-1:0] link_sig_i,
  input wire logic wan_stb_i,
  input wire dtp_slot_t wan_rx_i,
  input wire dtp_port_cfg_t [NPORT-1:0] port_cfg_o,
  input wire logic ext_clk_o,
  input wire logic [NPORT-1:0] clk_na_o,
  input wire logic [NPORT-1:0] slot_claim_o,
  input wire logic [NPORT-1:0] loop_latched_o,
  input wire logic wan_tx_valid_o,
  input wire dtp_slot_t wan_tx_o,
  input wire logic [NPORT-1:0] dte_bit_clk_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [NPORT-1:0] ok, ok_q, dp, lok, lok_q, cd, cd_q, nsl;
  logic hit;
  logic [4:0] s;
  // Expected claim, mode and loop qualifiers per port
  always_comb begin
    hit = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      s = port_cfg_o[p].slot_number;
      ok[p] = port_cfg_o[p].active && port_cfg_o[p].dest_wan && s >= SLOT_MIN
        && s <= (link_e1_i[port_cfg_o[p].link] ? SLOT_MAX_E1 : SLOT_MAX_T1)
        && !(link_e1_i[port_cfg_o[p].link] && link_sig_i[port_cfg_o[p].link] && s == SLOT_E1_SIG);
      dp[p] = port_cfg_o[p].mode == DTP_MODE_DP;
      cd[p] = port_cfg_o[p].mode == DTP_MODE_CODIR;
      lok[p] = dp[p] && port_cfg_o[p].latching_loop_detector != DTP_DET_OFF;
      nsl[p] = !port_cfg_o[p].dest_wan && s != SLOT_NA;
      hit = hit | (slot_claim_o[p] && wan_rx_i.link == port_cfg_o[p].link && wan_rx_i.slot == s);
    end
  end
  // Claims and loop clears lag the stored settings by one cycle
  always_ff @(posedge clk_i) begin
    ok_q <= ok;
    lok_q <= lok;
    cd_q <= cd;
  end
  a_claim_legal: assert property (slot_claim_o == ok_q) else $error("claim mismatch");
  a_none_slot: assert property (nsl == '0) else $error("slot kept with no destination");
  a_dp_spread: assert property (cfg_we_i && cfg_i.mode == DTP_MODE_DP |=> &dp)
    else $error("dataport not spread");
  a_g703_spread: assert property (cfg_we_i && cfg_i.mode != DTP_MODE_DP |=> dp == '0)
    else $error("dataport port left after G.703 write");
  a_ext_common: assert property (cfg_we_i |=> ext_clk_o == $past(cfg_ext_clk_i))
    else $error("clock source not shared");
  a_clk_na: assert property (clk_na_o == ~dp) else $error("clock n/a flag wrong");
  a_latch_dp: assert property ((loop_latched_o & ~lok_q) == '0)
    else $error("latched loop outside dataport detection");
  a_answer_hit: assert property (wan_stb_i |=> wan_tx_valid_o == $past(hit))
    else $error("answer does not follow a claimed slot");
  a_answer_echo: assert property (wan_tx_valid_o |-> $past(wan_stb_i)
    && wan_tx_o.link == $past(wan_rx_i.link) && wan_tx_o.slot == $past(wan_rx_i.slot))
    else $error("answer link or slot wrong");
  a_codir_clk: assert property ((dte_bit_clk_o & cd & cd_q) == '0)
    else $error("clock line driven in codirectional mode");
  c_answer: cover property (wan_tx_valid_o);
  c_latch: cover property (|loop_latched_o);
  c_codir: cover property (cfg_we_i && cfg_i.mode == DTP_MODE_CODIR);
endmodule

bind dtp_port dtp_port_props u_dtp_port_props (.*);

// file: verification/dtp_wan_net.sv
// Network side model: puts one slot byte on the slot bus per call.
// Each call waits for its own edge, so calls may run back to back; an idle bus shows the inverse of the last byte.
module dtp_wan_net
  import dtp_pkg::*;
(
  input wire logic clk_i,
  output logic stb_o,
  output dtp_slot_t rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet bus at time zero
  initial begin
    stb_o = 1'b0;
    rx_o = 16'hFFFF;
  end
  // Strobe for one edge, then invert the data lines
  task automatic send(input dtp_slot_t s);
    @(posedge clk_i);
    stb_o <= 1'b1;
    rx_o <= s;
    @(posedge clk_i);
    stb_o <= 1'b0;
    rx_o <= ~s;
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the port card: writes, slot answers, loops, DTE clocks.
// Assumes the network model on the slot bus and a free DTE clock at 320 ns.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dtp_pkg::*;
  logic clk_i, sys_rst_i, cfg_we_i, cfg_ext_clk_i, wan_stb_i, ext_clk_o, wan_tx_valid_o;
  logic dte_ext_bit_clk_i, dte_ext_byte_clk_i;
  logic [1:0] cfg_port_i;
  logic [2:0] bcnt;
  logic [NLINK-1:0] link_e1_i, link_sig_i;
  logic [NPORT-1:0] dte_txd_i, clk_na_o, slot_claim_o, loop_latched_o;
  logic [NPORT-1:0] dte_rxd_o, dte_bit_clk_o, dte_byte_clk_o;
  dtp_port_cfg_t cfg_i, c;
  dtp_port_cfg_t [NPORT-1:0] port_cfg_o;
  dtp_slot_t wan_rx_i, wan_tx_o;
  dtp_port_cfg_t ec [NPORT];
  logic eext;
  int failures, n_tests, seed, nb, ny;
  logic txfix;
  // One byte period of system clocks and the shortened loop timeout
  localparam int BYTE_CYC = int'(CLK_HZ / (BIT_HZ >> 3));
  localparam logic [TO_W-1:0] LOOP_TO = 34'h0_0000_00C8;
  dtp_port #(.LOOP_TIMEOUT_CYC(LOOP_TO)) u_dtp_port (.*);
  dtp_wan_net u_dtp_wan_net (.clk_i(clk_i), .stb_o(wan_stb_i), .rx_o(wan_rx_i));
  // System clock and free DTE clock with a byte mark every eighth bit
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    dte_ext_bit_clk_i = 1'b1; // Starts high so time zero gives no false falling edge
    forever #160 dte_ext_bit_clk_i = ~dte_ext_bit_clk_i;
  end
  always @(negedge dte_ext_bit_clk_i) begin
    bcnt <= bcnt + 3'h1;
    dte_ext_byte_clk_i <= bcnt == 3'h7;
    dte_txd_i <= txfix ? 4'hF : 4'($random(seed));
  end
  task automatic stop_test();
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic claimx(input dtp_port_cfg_t k);
    logic e1;
    e1 = link_e1_i[k.link];
    return k.active && k.dest_wan && k.slot_number >= SLOT_MIN && k.slot_number
      <= (e1 ? SLOT_MAX_E1 : SLOT_MAX_T1)
      && !(e1 && link_sig_i[k.link] && k.slot_number == SLOT_E1_SIG);
  endfunction
  function automatic dtp_port_cfg_t mk(dtp_lb_t l, dtp_gen_t g, dtp_det_t d, dtp_mode_t m);
    mk = '{1'b1, 1'b1, 3'h3, 5'h05, m, l, g, d};
  endfunction
  function automatic logic [7:0] code(input dtp_gen_t g);
    case (g)
      DTP_GEN_OCU: return CODE_OCU;
      DTP_GEN_DSU: return CODE_DSU;
      DTP_GEN_CSU: return CODE_CSU;
      default: return CODE_DS0;
    endcase
  endfunction
  // Compare every stored setting and claim with the model
  // Settings and flags follow a write by one cycle, claims by one more
  task automatic cmp_all();
    #1;
    for (int q = 0; q < NPORT; q++) begin
      chk("cfg", ec[q], port_cfg_o[q]);
      chk("clk_na", ec[q].mode != DTP_MODE_DP, clk_na_o[q]);
    end
    chk("ext_clk", eext, ext_clk_o);
    @(posedge clk_i);
    #1;
    for (int q = 0; q < NPORT; q++) begin
      chk("claim", claimx(ec[q]), slot_claim_o[q]);
    end
  endtask
  task automatic wr(input logic [1:0] p, input dtp_port_cfg_t k, input logic x);
    @(posedge clk_i);
    cfg_we_i <= 1'b1;
    cfg_port_i <= p;
    cfg_i <= k;
    cfg_ext_clk_i <= x;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
    if (!k.dest_wan) k.slot_number = SLOT_NA;
    for (int q = 0; q < NPORT; q++)
      if (k.mode == DTP_MODE_DP) ec[q].mode = DTP_MODE_DP;
      else if (ec[q].mode == DTP_MODE_DP) ec[q].mode = DTP_MODE_CONTR;
    ec[p] = k;
    eext = x;
    cmp_all();
  endtask
  task automatic tx(input logic [4:0] s, input logic [7:0] d, input logic v, input logic [7:0] e);
    u_dtp_wan_net.send('{3'h3, s, d});
    #1;
    chk("tx_valid", v, wan_tx_valid_o);
    if (v) chk("tx", {3'h3, s, e}, wan_tx_o);
  endtask
  task automatic latch(input dtp_det_t d, input dtp_mode_t m, input logic e);
    wr(0, mk(DTP_LB_OFF, DTP_GEN_OFF, d, m), 1'b0);
    repeat (3) u_dtp_wan_net.send('{3'h3, 5'h05, CODE_DSU});
    @(posedge clk_i);
    #1;
    chk("latched", e, loop_latched_o[0]);
  endtask
  // Count rising DTE clock edges on port 0 over one byte period, after one to settle
  task automatic clocks(input int eb, input int ey);
    logic b, y;
    nb = 0;
    ny = 0;
    repeat (BYTE_CYC) @(posedge clk_i);
    #1;
    b = dte_bit_clk_o[0];
    y = dte_byte_clk_o[0];
    repeat (BYTE_CYC) begin
      @(posedge clk_i);
      #1;
      nb += int'(dte_bit_clk_o[0] && !b);
      ny += int'(dte_byte_clk_o[0] && !y);
      b = dte_bit_clk_o[0];
      y = dte_byte_clk_o[0];
    end
    chk("bit_clk", eb, nb);
    chk("byte_clk", ey, ny);
  endtask
  // Watchdog well above the longest run of about 40000 cycles
  initial begin
    #3000000;
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    {sys_rst_i, cfg_we_i, cfg_port_i, cfg_i, cfg_ext_clk_i, bcnt} = '0;
    sys_rst_i = 1'b1;
    {dte_txd_i, dte_ext_byte_clk_i} = '0;
    txfix = 1'b0;
    link_e1_i = 8'h0F;
    link_sig_i = 8'h05;
    seed = 32'heb2e;
    foreach (ec[q]) ec[q] = CFG_RESET;
    eext = 1'b0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    cmp_all();
    for (int i = 0; i < 40; i++) begin
      c = 19'($random(seed));
      c.mode = dtp_mode_t'(2'($unsigned($random(seed)) % 3));
      c.local_loop_select = DTP_LB_OFF;
      c.remote_loop_code_send = DTP_GEN_OFF;
      c.latching_loop_detector = DTP_DET_OFF;
      if (i < 6) c = '{1'b1, 1'b1, 3'(i % 3 * 2), 5'(16 + i * 3 % 10), DTP_MODE_DP,
                       DTP_LB_OFF, DTP_GEN_OFF, DTP_DET_OFF};
      wr(2'(i), c, 1'($random(seed)));
    end
    wr(0, mk(DTP_LB_NET, DTP_GEN_OFF, DTP_DET_OFF, DTP_MODE_DP), 1'b0);
    tx(5'h05, 8'h5A, 1'b1, 8'h5A);
    tx(5'h06, 8'h5A, 1'b0, 8'h00);
    for (int g = 1; g < 5; g++) begin
      wr(0, mk(DTP_LB_OFF, dtp_gen_t'(g), DTP_DET_OFF, DTP_MODE_DP), 1'b0);
      tx(5'h05, 8'h11, 1'b1, code(dtp_gen_t'(g)));
    end
    latch(DTP_DET_OFF, DTP_MODE_DP, 1'b0);
    latch(DTP_DET_ENAB, DTP_MODE_CONTR, 1'b0);
    latch(DTP_DET_ENAB, DTP_MODE_DP, 1'b1);
    tx(5'h05, 8'h33, 1'b1, 8'h33);
    repeat (3) u_dtp_wan_net.send('{3'h3, 5'h05, CODE_LOOP_DOWN});
    @(posedge clk_i);
    #1;
    chk("loop_down", 1'b0, loop_latched_o[0]);
    latch(DTP_DET_TO, DTP_MODE_DP, 1'b1);
    // Latched one edge before that check; the release falls LOOP_TO cycles after latching
    repeat (int'(LOOP_TO) - 2) @(posedge clk_i);
    #1;
    chk("hold", 1'b1, loop_latched_o[0]);
    @(posedge clk_i);
    #1;
    chk("timeout", 1'b0, loop_latched_o[0]);
    // DTE clocks: dataport internal and external, contradirectional, codirectional
    clocks(8, 1);
    wr(2'h0, mk(DTP_LB_OFF, DTP_GEN_OFF, DTP_DET_OFF, DTP_MODE_DP), 1'b1);
    clocks(0, 0);
    wr(2'h1, mk(DTP_LB_OFF, DTP_GEN_OFF, DTP_DET_OFF, DTP_MODE_CONTR), 1'b1);
    clocks(8, 1);
    wr(2'h0, mk(DTP_LB_OFF, DTP_GEN_OFF, DTP_DET_OFF, DTP_MODE_CODIR), 1'b1);
    clocks(0, 0);
    // DTE sends all ones: slot byte toward DTE, DTE byte toward network, loop toward DTE
    txfix = 1'b1;
    wr(2'h0, mk(DTP_LB_OFF, DTP_GEN_OFF, DTP_DET_OFF, DTP_MODE_DP), 1'b0);
    u_dtp_wan_net.send('{3'h3, 5'h05, 8'h00});
    repeat (2 * BYTE_CYC) @(posedge clk_i);
    #1;
    chk("rxd", 1'b0, dte_rxd_o[0]);
    tx(5'h05, 8'h00, 1'b1, 8'hFF);
    wr(2'h0, mk(DTP_LB_DTE, DTP_GEN_OFF, DTP_DET_OFF, DTP_MODE_DP), 1'b0);
    repeat (2 * BYTE_CYC) @(posedge clk_i);
    #1;
    chk("rxd_loop", 1'b1, dte_rxd_o[0]);
    stop_test();
  end
endmodule
